// ==== logic/sfd_pkg.sv ====
// Package of constants and types for the supply fault detector logic
package sfd_pkg;
   // Channel counts
   localparam int NUM_CH = 10;
   localparam int NUM_DED = 5;
   localparam int NUM_DUAL = 5;
   // Code widths
   localparam int THR_W = 8;
   localparam int HYS_W = 5;
   // Full-scale code of the threshold and hysteresis equations
   localparam int FULL_CODE = 255;
   // Largest hysteresis code
   localparam logic [HYS_W-1:0] HYS_MAX = 5'h1f;
   // Range bottoms and spans in millivolts, index by range select
   localparam int RANGE_BOT_MV [4] = '{573, 1250, 2500, 6000};
   localparam int RANGE_SPAN_MV [4] = '{802, 1750, 3500, 8400};
   // Filter timing
   localparam int CLK_MHZ = 100;
   localparam int FILT_MAX_US = 100;
   localparam int FILT_MAX_CYC = FILT_MAX_US * CLK_MHZ;
   localparam int FILT_W = 14;
   // Reset values
   localparam logic RST_FLAG = 1'b0;
   localparam logic [FILT_W-1:0] RST_CNT = 14'h0000;
   // Fault modes
   typedef enum logic [1:0] {
      MODE_UV,
      MODE_OV,
      MODE_WIN,
      MODE_OFF
   } fault_mode_t;
   // Threshold in mV for a range and code, used for both comparisons
   function automatic int thr_mv(input logic [1:0] rng,
                                 input logic [THR_W-1:0] code);
      thr_mv = RANGE_BOT_MV[rng]
               + (RANGE_SPAN_MV[rng] * int'(code)) / FULL_CODE;
   endfunction
   // Hysteresis in mV for a range and code
   function automatic int hys_mv(input logic [1:0] rng,
                                 input logic [HYS_W-1:0] code);
      hys_mv = (RANGE_SPAN_MV[rng] * int'(code)) / FULL_CODE;
   endfunction
endpackage

// ==== logic/glitch_filter.sv ====
// Per-channel glitch filter with programmable timeout
`timescale 1ns/1ps
module glitch_filter
   import sfd_pkg::*;
#(
   parameter int CNT_W = FILT_W
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic raw_i,
   input wire logic [CNT_W-1:0] timeout_i,
   output logic filt_o
);
   logic [CNT_W-1:0] cnt_r;
   logic filt_r;

   assign filt_o = filt_r;

   // Count cycles the input differs from output; reset count on agreement
   // hides short pulses
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= CNT_W'(RST_CNT);
      end else if (raw_i == filt_r || cnt_r >= timeout_i) begin
         cnt_r <= CNT_W'(RST_CNT);
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // Output follows once the input held for the timeout
   // delayed by timeout plus one cycle, zero passes after one cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         filt_r <= RST_FLAG;
      end else if (raw_i != filt_r && cnt_r >= timeout_i) begin
         filt_r <= raw_i;
      end
   end

   // output moves only to the input value of the cycle before
   AST_FILT_DELAY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (filt_r != $past(filt_r)) |-> $past(raw_i) == filt_r)
      else $error("Filter output moved away from held input");
   // output never changes while count below timeout
   AST_FILT_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (cnt_r < timeout_i && raw_i != filt_r) |=> $stable(filt_r))
      else $error("Filter passed a pulse shorter than timeout");
   // zero timeout follows input in one cycle
   AST_FILT_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (timeout_i == '0 && $stable(timeout_i))
      |=> filt_r == $past(raw_i))
      else $error("Zero timeout added delay");
endmodule

// ==== logic/supply_fault_detector_logic.sv ====
// Top of the ten-channel supply fault detector logic
`timescale 1ns/1ps
module supply_fault_detector_logic
   import sfd_pkg::*;
#(
   parameter int N_CH = NUM_CH,
   parameter int N_DUAL = NUM_DUAL
) (
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   // Measured input level of each channel in mV from the rail front end
   input wire logic [N_CH*16-1:0] RAIL_MV_I,
   // Per-channel configuration
   input wire logic [N_CH*2-1:0] RANGE_SEL_I,
   input wire logic [N_CH*2-1:0] FAULT_MODE_I,
   input wire logic [N_CH*THR_W-1:0] UV_THR_I,
   input wire logic [N_CH*THR_W-1:0] OV_THR_I,
   input wire logic [N_CH*HYS_W-1:0] HYS_CODE_I,
   input wire logic [N_CH*FILT_W-1:0] FILT_CYC_I,
   // Dual-function inputs: 1 selects logic input use
   input wire logic [N_DUAL-1:0] DUAL_LOGIC_SEL_I,
   input wire logic [N_DUAL-1:0] DUAL_LOGIC_PIN_I,
   output logic [N_CH-1:0] FAULT_O,
   output logic [N_CH-1:0] FAULT_STATUS_O,
   output logic [N_CH-1:0] UV_STATUS_O,
   output logic [N_CH-1:0] OV_STATUS_O,
   output logic [N_DUAL-1:0] DUAL_LOGIC_O
);
   logic [N_DUAL-1:0] pin_s1_r;
   logic [N_DUAL-1:0] pin_s2_r;
   logic [N_CH-1:0] uv_r;
   logic [N_CH-1:0] ov_r;
   logic [N_CH-1:0] raw_r;
   logic [N_CH-1:0] filt;
   logic [N_DUAL-1:0] dig_filt;
   logic [N_CH-1:0] fault_r;
   logic [N_DUAL-1:0] dig_r;

   // cap filter count at 100 us
   // Counts above the ceiling act as the ceiling rather than wrapping
   function automatic logic [FILT_W-1:0] clamp_tmo(
      input logic [FILT_W-1:0] cyc
   );
      if (int'(cyc) > FILT_MAX_CYC) begin
         clamp_tmo = FILT_W'(FILT_MAX_CYC);
      end else begin
         clamp_tmo = cyc;
      end
   endfunction

   // Two-stage synchroniser for the logic-input pins
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end else begin
         pin_s1_r <= DUAL_LOGIC_PIN_I;
         pin_s2_r <= pin_s1_r;
      end
   end

   genvar g;
   generate
      for (g = 0; g < N_CH; g++) begin : g_ch
         logic [1:0] rng;
         logic [15:0] mv;
         logic [HYS_W-1:0] hys;
         int uv_t;
         int ov_t;
         int hv;
         logic uv_nxt;
         logic ov_nxt;
         logic raw_nxt;
         logic is_logic;
         logic [FILT_W-1:0] tmo;
         assign rng = RANGE_SEL_I[g*2 +: 2];
         assign mv = RAIL_MV_I[g*16 +: 16];
         // Hysteresis code taken straight from its 5-bit field, no clamp
         assign hys = HYS_CODE_I[g*HYS_W +: HYS_W];
         assign uv_t = thr_mv(rng, UV_THR_I[g*THR_W +: THR_W]);
         assign ov_t = thr_mv(rng, OV_THR_I[g*THR_W +: THR_W]);
         // hysteresis worth span times code over 255
         assign hv = hys_mv(rng, hys);
         assign tmo = clamp_tmo(FILT_CYC_I[g*FILT_W +: FILT_W]);
         // Dual channels sit in the upper five slots
         if (g >= N_CH - N_DUAL) begin : g_dual
            assign is_logic = DUAL_LOGIC_SEL_I[g - (N_CH - N_DUAL)];
         end else begin : g_ded
            assign is_logic = 1'b0;
         end

         // Comparisons with hysteresis only once a fault is held
         always_comb begin
            // undervoltage clears above threshold plus hysteresis
            if (uv_r[g]) begin
               uv_nxt = int'(mv) <= uv_t + hv;
            end else begin
               uv_nxt = int'(mv) < uv_t;
            end
            // overvoltage clears below threshold minus hysteresis
            if (ov_r[g]) begin
               ov_nxt = int'(mv) >= ov_t - hv;
            end else begin
               ov_nxt = int'(mv) > ov_t;
            end
            case (fault_mode_t'(FAULT_MODE_I[g*2 +: 2]))
               MODE_UV: raw_nxt = uv_r[g];
               MODE_OV: raw_nxt = ov_r[g];
               MODE_WIN: raw_nxt = uv_r[g] | ov_r[g];
               default: raw_nxt = 1'b0;
            endcase
            if (is_logic) begin
               raw_nxt = 1'b0;
            end
         end

         // both comparisons update every cycle whatever the mode
         always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
               uv_r[g] <= RST_FLAG;
               ov_r[g] <= RST_FLAG;
               raw_r[g] <= RST_FLAG;
            end else begin
               uv_r[g] <= uv_nxt;
               ov_r[g] <= ov_nxt;
               raw_r[g] <= raw_nxt;
            end
         end

         // filter follows hysteresis, ahead of the output register
         glitch_filter #(.CNT_W(FILT_W)) u_filt (
            .clk_i(REF_CLK_I),
            .rst_n_i(RST_N_I),
            .raw_i(raw_r[g]),
            .timeout_i(tmo),
            .filt_o(filt[g])
         );

         // held undervoltage stays while inside hysteresis band
         AST_UV_HOLD: assert property (@(posedge REF_CLK_I)
            disable iff (!RST_N_I)
            (uv_r[g] && int'(mv) <= uv_t + hv) |=> uv_r[g])
            else $error("Undervoltage cleared inside hysteresis");
         // held overvoltage stays while inside hysteresis band
         AST_OV_HOLD: assert property (@(posedge REF_CLK_I)
            disable iff (!RST_N_I)
            (ov_r[g] && int'(mv) >= ov_t - hv) |=> ov_r[g])
            else $error("Overvoltage cleared inside hysteresis");
         // undervoltage sets below threshold in any mode
         AST_UV_SET: assert property (@(posedge REF_CLK_I)
            disable iff (!RST_N_I)
            (int'(mv) < uv_t) |=> uv_r[g])
            else $error("Undervoltage not flagged");
         // overvoltage sets above threshold in any mode
         AST_OV_SET: assert property (@(posedge REF_CLK_I)
            disable iff (!RST_N_I)
            (int'(mv) > ov_t) |=> ov_r[g])
            else $error("Overvoltage not flagged");
         // detector off never raises a fault
         AST_MODE_OFF: assert property (@(posedge REF_CLK_I)
            disable iff (!RST_N_I)
            (FAULT_MODE_I[g*2 +: 2] == 2'h3) |=> !raw_r[g])
            else $error("Fault raised with detector off");
         // window fault is the OR of both
         AST_WIN_OR: assert property (@(posedge REF_CLK_I)
            disable iff (!RST_N_I)
            (FAULT_MODE_I[g*2 +: 2] == 2'h2 && !is_logic)
            |=> raw_r[g] == ($past(uv_r[g]) | $past(ov_r[g])))
            else $error("Window fault is not OR of comparisons");
         AST_THR_RANGE: assert property (@(posedge REF_CLK_I)
            disable iff (!RST_N_I)
            uv_t <= RANGE_BOT_MV[rng] + RANGE_SPAN_MV[rng])
            else $error("Threshold outside range");
         // hysteresis never exceeds span times 31/255
         AST_HYS_MAX: assert property (@(posedge REF_CLK_I)
            disable iff (!RST_N_I)
            hv <= (RANGE_SPAN_MV[rng] * int'(HYS_MAX)) / FULL_CODE)
            else $error("Hysteresis beyond maximum");
         COV_UV: cover property (@(posedge REF_CLK_I) uv_r[g] ##1 !uv_r[g]);
         COV_OV: cover property (@(posedge REF_CLK_I) ov_r[g] ##1 !ov_r[g]);
         COV_FAULT: cover property (@(posedge REF_CLK_I) $rose(filt[g]));
         COV_WIN: cover property (@(posedge REF_CLK_I)
            raw_r[g] && FAULT_MODE_I[g*2 +: 2] == 2'h2);
      end
      // Logic-input path has its own instance of the same filter, with the channel's timeout
      for (g = 0; g < N_DUAL; g++) begin : g_dig
         glitch_filter #(.CNT_W(FILT_W)) u_dfilt (
            .clk_i(REF_CLK_I),
            .rst_n_i(RST_N_I),
            .raw_i(pin_s2_r[g] & DUAL_LOGIC_SEL_I[g]),
            .timeout_i(clamp_tmo(FILT_CYC_I[(N_CH-N_DUAL+g)*FILT_W +: FILT_W])),
            .filt_o(dig_filt[g])
         );
      end
   endgenerate

   // Register outputs; fault flag feeds engine and status alike
   // filtered flag to engine and status
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         fault_r <= '0;
         dig_r <= '0;
      end else begin
         fault_r <= filt;
         dig_r <= dig_filt;
      end
   end

   assign FAULT_O = fault_r;
   assign FAULT_STATUS_O = fault_r;
   assign UV_STATUS_O = uv_r;
   assign OV_STATUS_O = ov_r;
   assign DUAL_LOGIC_O = dig_r;

   AST_STATUS_EQ: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
      $past(filt) == fault_r)
      else $error("Status lags filtered fault");
   // dedicated channel stays analog
   // Watches the dedicated slot next to the duals, where a slip would show
   AST_DED_ANALOG: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
      (uv_r[N_CH-N_DUAL-1] && FAULT_MODE_I[(N_CH-N_DUAL-1)*2 +: 2] == 2'h0)
      |=> raw_r[N_CH-N_DUAL-1])
      else $error("Dedicated channel not monitored");
   AST_DUAL_MASK: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
      DUAL_LOGIC_SEL_I[0] |=> !raw_r[N_CH-N_DUAL])
      else $error("Logic-input channel raised an analog fault");
   COV_DIG: cover property (@(posedge REF_CLK_I) $rose(dig_r[0]));
endmodule

// ==== verif/rail_sense_model.sv ====
// Rail front end and sequencing-engine stand-in for the fault logic
`timescale 1ns/1ps
module rail_sense_model
   import sfd_pkg::*;
(
   input wire logic [15:0] level_i,
   input wire logic [NUM_CH-1:0] fault_i,
   output logic [NUM_CH*16-1:0] rail_mv_o,
   output logic any_fault_o
);
   // Every rail sits at the same level so all channels must agree
   assign rail_mv_o = {NUM_CH{level_i}};
   // Sequencing engine only acts on the OR of the filtered flags
   assign any_fault_o = |fault_i;
endmodule

// ==== verif/supply_fault_detector_logic_tb_top.sv ====
// Self-checking bench for the supply fault detector logic
`timescale 1ns/1ps
module supply_fault_detector_logic_tb_top;
   import sfd_pkg::*;
   typedef struct {
      logic [1:0] md;
      logic [15:0] mv;
      logic u;
      logic o;
      logic f;
   } row_t;
   logic ref_clk, rst_n, any_fault;
   logic [15:0] level;
   logic [1:0] mode, rng;
   logic [13:0] tmo;
   logic [4:0] dsel, dpin, dlog;
   logic [NUM_CH*16-1:0] rail_mv;
   logic [9:0] fault, fstat, uvs, ovs;
   int fails, compares, n;
   // Range 2: uv code 100 is 3872 mV, ov code 200 is 5245 mV, hys 10 is 137
   row_t rows [13] = '{
      '{2'h0, 16'h1194, 1'b0, 1'b0, 1'b0}, '{2'h0, 16'h0ed8, 1'b1, 1'b0, 1'b1},
      '{2'h0, 16'h0f6e, 1'b1, 1'b0, 1'b1}, '{2'h0, 16'h0fb4, 1'b0, 1'b0, 1'b0},
      '{2'h1, 16'h14b4, 1'b0, 1'b1, 1'b1}, '{2'h1, 16'h141e, 1'b0, 1'b1, 1'b1},
      '{2'h1, 16'h13ec, 1'b0, 1'b0, 1'b0}, '{2'h2, 16'h0ed8, 1'b1, 1'b0, 1'b1},
      '{2'h2, 16'h1194, 1'b0, 1'b0, 1'b0}, '{2'h2, 16'h14b4, 1'b0, 1'b1, 1'b1},
      '{2'h0, 16'h14b4, 1'b0, 1'b1, 1'b0}, '{2'h3, 16'h0ed8, 1'b1, 1'b0, 1'b0},
      '{2'h0, 16'h1194, 1'b0, 1'b0, 1'b0}};

   supply_fault_detector_logic uut (
      .REF_CLK_I(ref_clk), .RST_N_I(rst_n), .RAIL_MV_I(rail_mv),
      .RANGE_SEL_I({10{rng}}), .FAULT_MODE_I({10{mode}}),
      .UV_THR_I({10{8'h64}}), .OV_THR_I({10{8'hc8}}),
      .HYS_CODE_I({10{5'h0a}}), .FILT_CYC_I({10{tmo}}),
      .DUAL_LOGIC_SEL_I(dsel), .DUAL_LOGIC_PIN_I(dpin),
      .FAULT_O(fault), .FAULT_STATUS_O(fstat), .UV_STATUS_O(uvs),
      .OV_STATUS_O(ovs), .DUAL_LOGIC_O(dlog));

   rail_sense_model partner (.level_i(level), .fault_i(fault),
      .rail_mv_o(rail_mv), .any_fault_o(any_fault));

   // Free-running 100 MHz reference
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic chk(input string nm, input logic [9:0] exp,
                      input logic [9:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("fails %0d compares %0d", fails, compares);
      if (fails == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Counts cycles until every flag is up; a hang ends the run
   task automatic wait_all(input int lim, output int cnt);
      for (cnt = 1; cnt <= lim; cnt++) begin
         @(negedge ref_clk);
         if (fault === 10'h3ff)
            return;
      end
      fails++;
      $display("ERROR wait_all expected 3ff seen %h", fault);
      wrap_up();
   endtask

   initial begin
      rst_n = 1'b0;
      level = 16'h1194;
      mode = 2'h0;
      rng = 2'h2;
      tmo = 14'h0000;
      dsel = 5'h00;
      dpin = 5'h00;
      repeat (16) @(negedge ref_clk);
      chk("fault_in_reset", 10'h000, fault);
      rst_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      // Table walk, state carries over from row to row
      foreach (rows[i]) begin
         mode = rows[i].md;
         level = rows[i].mv;
         repeat (6) @(negedge ref_clk);
         chk("uv_status", {10{rows[i].u}}, uvs);
         chk("ov_status", {10{rows[i].o}}, ovs);
         chk("fault", {10{rows[i].f}}, fault);
         chk("fault_status", {10{rows[i].f}}, fstat);
      end
      // Lowest range: uv code 100 is 887 mV, hysteresis 10 is 31 mV
      rng = 2'h0;
      level = 16'h0370;
      repeat (6) @(negedge ref_clk);
      chk("uv_low_range", 10'h3ff, uvs);
      level = 16'h0384;
      repeat (6) @(negedge ref_clk);
      chk("uv_low_band", 10'h3ff, uvs);
      level = 16'h0398;
      repeat (6) @(negedge ref_clk);
      chk("uv_low_clear", 10'h000, uvs);
      rng = 2'h2;
      level = 16'h1194;
      repeat (6) @(negedge ref_clk);
      // Zero timeout passes a crossing within a few edges
      level = 16'h0ed8;
      wait_all(60, n);
      chk("zero_delay", 10'h001, 10'(n <= 4));
      chk("seq_any_fault", 10'h001, {9'h000, any_fault});
      level = 16'h1194;
      tmo = 14'h0014;
      repeat (40) @(negedge ref_clk);
      // Ten-cycle dip against a twenty-cycle timeout is hidden
      level = 16'h0ed8;
      repeat (10) @(negedge ref_clk);
      level = 16'h1194;
      n = 0;
      repeat (40) begin
         @(negedge ref_clk);
         if (fault !== 10'h000)
            n++;
      end
      chk("short_pulse", 10'h000, 10'(n));
      // Long dip passes, late by the timeout
      level = 16'h0ed8;
      wait_all(60, n);
      chk("filter_delay", 10'h001, 10'(n >= 20 && n <= 25));
      // Logic pins are ignored until the dual input is switched over
      tmo = 14'h0000;
      dpin = 5'h1f;
      repeat (10) @(negedge ref_clk);
      chk("dual_logic_off", 10'h000, {5'h00, dlog});
      // Dual inputs switched to logic use drop their analog fault
      dsel = 5'h1f;
      repeat (10) @(negedge ref_clk);
      chk("dual_fault", 10'h01f, fault);
      chk("dual_logic", 10'h01f, {5'h00, dlog});
      dpin = 5'h0a;
      repeat (10) @(negedge ref_clk);
      chk("dual_logic", 10'h00a, {5'h00, dlog});
      // Reset in mid-run drops held faults
      rst_n = 1'b0;
      @(negedge ref_clk);
      chk("fault_mid_reset", 10'h000, fault);
      rst_n = 1'b1;
      repeat (10) @(negedge ref_clk);
      chk("fault_after_reset", 10'h01f, fault);
      wrap_up();
   end
endmodule
